// *** ocm_top.sv ***
// Output clock matrix: management bus slave, input select, dividers, outputs
//
// What this block does
// RQ1 - With control function 00, a low control pin forces plain outputs low and inverted high.
// RQ2 - With control function 01, a low control pin tri-states every output; 10 and 11 reserved.
// RQ3 - The input-select bit picks clock input a when 0 (default) and b when 1.
// RQ4 - The input-select bit is ignored in crystal and differential input modes.
// RQ5 - Source code 00 is crystal (default), 10 differential, 11 reserved.
// RQ6 - Source code 01 makes both inputs single-ended, picked by the input-select bit or pin.
// RQ7 - Power-down bit 1 stops PLLs and input stage, tri-states outputs, keeps registers and bus.
// RQ8 - Power-down wins over any tri-state or forced-low state asked for by the pins.
// RQ9 - Each post-divider divides its source by its 7-bit code, 1 to 127, code 0 not allowed.
// RQ10 - Post-divider ratios reset to 10, 20, 8, 9, 32 and 4.
// RQ11 - Each output has a 3-bit divider select, codes 0 to 5, default divider two.
// RQ12 - An output drives its clock when enabled (default) and holds low when disabled.
// RQ13 - An output passes its clock when invert is 0 (default) and its complement when 1.
// RQ14 - Each divider source code picks bypass, PLL1, PLL2, PLL2 spread or PLL3.
// RQ15 - With the power pin set for input selection, its level overrides the input-select bit.
// RQ16 - Software must not write reserved codes or a zero divide ratio.
`timescale 1ns/100ps
module ocm_top #(
	parameter logic [6:0] BUS_ADDRESS = 7'h50 // Arbitrary value
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Management bus
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// Control pins
	input wire logic i_output_control_pin,
	input wire logic i_power_control_pin,
	// Clock sources
	input wire logic i_clock_input_a,
	input wire logic i_clock_input_b,
	input wire ocm_pkg::ocm_pll_clks_t i_pll_clks,
	// Towards the PLL section
	output logic o_input_clock,
	output logic o_pll_power_down,
	output logic o_input_stage_power_down,
	// Clock outputs
	output logic [ocm_pkg::NUM_OUT-1:0] o_clock_output_n,
	output logic [ocm_pkg::NUM_OUT-1:0] o_clock_output_oe
);

	// ************************************************************
	// Register map helpers
	// ************************************************************
	function automatic logic reg_hit(input logic [7:0] ofs);
		reg_hit = (ofs >= ocm_pkg::OFS_CTL_PIN) && (ofs <= ocm_pkg::OFS_LAST) &&
			(ofs != ocm_pkg::OFS_SSC_GAP) && (ofs != ocm_pkg::OFS_CNT_GAP);
	endfunction

	function automatic logic [4:0] reg_idx(input logic [7:0] ofs);
		reg_idx = 5'(ofs - ocm_pkg::OFS_CTL_PIN);
	endfunction

	// ************************************************************
	// Bus pin sampling
	// ************************************************************
	logic scl_q, scl_d, scl_prev_q, scl_prev_d;
	logic sda_q, sda_d, sda_prev_q, sda_prev_d;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	always_comb begin
		scl_d = i_scl;
		sda_d = i_sda;
		scl_prev_d = scl_q;
		sda_prev_d = sda_q;
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_q <= scl_d;
			sda_q <= sda_d;
			scl_prev_q <= scl_prev_d;
			sda_prev_q <= sda_prev_d;
		end
	end

	assign scl_rise = scl_q && !scl_prev_q;
	assign scl_fall = !scl_q && scl_prev_q;
	assign bus_start = scl_q && scl_prev_q && sda_prev_q && !sda_q;
	assign bus_stop = scl_q && scl_prev_q && !sda_prev_q && sda_q;

	// ************************************************************
	// Bus slave state machine
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACKWAIT, ST_ACK, ST_RDATA, ST_MACK
	} ocm_bus_state_t;

	ocm_bus_state_t st_q, st_d, after_q, after_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] shift_q, shift_d;
	logic [7:0] ptr_q, ptr_d;
	logic oe_q, oe_d;
	logic [7:0] next_byte;
	logic [7:0] rd_byte;
	logic wr_en;
	logic [7:0] wr_byte;
	logic [7:0] regs_q [ocm_pkg::NUM_REGS];
	logic [7:0] regs_d [ocm_pkg::NUM_REGS];

	// Unmapped offsets read as zero and ignore writes
	assign rd_byte = reg_hit(ptr_q) ? regs_q[reg_idx(ptr_q)] : 8'h00;

	always_comb begin
		st_d = st_q;
		after_d = after_q;
		bit_d = bit_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		oe_d = oe_q;
		wr_en = 1'b0;
		wr_byte = 8'h00;
		next_byte = {shift_q[6:0], sda_q};
		if (bus_start) begin
			st_d = ST_ADDR;
			bit_d = 3'h0;
			oe_d = 1'b0;
		end else if (bus_stop) begin
			st_d = ST_IDLE;
			oe_d = 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					oe_d = 1'b0;
				end
				ST_ADDR, ST_CMD, ST_WDATA: begin
					if (scl_rise) begin
						shift_d = next_byte;
						bit_d = bit_q + 3'h1;
						if (bit_q == 3'h7) begin
							st_d = ST_ACKWAIT;
							if (st_q == ST_ADDR) begin
								if (next_byte[7:1] != BUS_ADDRESS) begin
									st_d = ST_IDLE;
								end
								after_d = next_byte[0] ? ST_RDATA : ST_CMD;
							end else if (st_q == ST_CMD) begin
								ptr_d = next_byte;
								after_d = ST_WDATA;
							end else begin
								wr_en = 1'b1;
								wr_byte = next_byte;
								ptr_d = ptr_q + 8'h01;
								after_d = ST_WDATA;
							end
						end
					end
				end
				ST_ACKWAIT: begin
					if (scl_fall) begin
						oe_d = 1'b1;
						st_d = ST_ACK;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						oe_d = 1'b0;
						bit_d = 3'h0;
						st_d = after_q;
						if (after_q == ST_RDATA) begin
							shift_d = rd_byte;
							ptr_d = ptr_q + 8'h01;
							oe_d = !rd_byte[7];
						end
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bit_q == 3'h7) begin
							oe_d = 1'b0;
							st_d = ST_MACK;
						end else begin
							bit_d = bit_q + 3'h1;
							oe_d = !shift_q[6];
							shift_d = {shift_q[6:0], 1'b0};
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						st_d = sda_q ? ST_IDLE : ST_ACK;
						after_d = ST_RDATA;
					end
				end
				default: begin
					st_d = ST_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_q <= ST_IDLE;
			after_q <= ST_IDLE;
			bit_q <= 3'h0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			oe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			after_q <= after_d;
			bit_q <= bit_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			oe_q <= oe_d;
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = oe_q;

	// ************************************************************
	// Register file
	// ************************************************************
	// Contents survive power-down; only reset returns the defaults
	always_comb begin
		regs_d = regs_q;
		if (wr_en && reg_hit(ptr_q)) begin
			regs_d[reg_idx(ptr_q)] = wr_byte; // RQ7
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			regs_q <= ocm_pkg::RESET_BYTES; // RQ10
		end else begin
			regs_q <= regs_d;
		end
	end

	// ************************************************************
	// Input stage and power control
	// ************************************************************
	logic [1:0] ctl_func, pwr_func, in_src;
	logic sel_level, pwr_down, bypass, in_clk;

	assign ctl_func = regs_q[reg_idx(ocm_pkg::OFS_CTL_PIN)][ocm_pkg::CTL_FUNC_LSB +: 2];
	assign in_src = regs_q[reg_idx(ocm_pkg::OFS_IN_SRC)][ocm_pkg::INPUT_SOURCE_LSB +: 2];
	assign pwr_func = regs_q[reg_idx(ocm_pkg::OFS_PWR)][ocm_pkg::PWR_FUNC_LSB +: 2];

	always_comb begin
		sel_level = regs_q[reg_idx(ocm_pkg::OFS_CTL_PIN)][ocm_pkg::INPUT_SELECT_BIT]; // RQ3
		if (pwr_func == ocm_pkg::PWR_FUNC_INSEL) begin
			sel_level = i_power_control_pin; // RQ15 RQ6
		end
		case (in_src)
			ocm_pkg::SRC_SINGLE: in_clk = sel_level ? i_clock_input_b : i_clock_input_a; // RQ6
			// Crystal and differential both enter on input a; select is ignored
			ocm_pkg::SRC_CRYSTAL: in_clk = i_clock_input_a; // RQ4 RQ5
			ocm_pkg::SRC_DIFF: in_clk = i_clock_input_a; // RQ4 RQ5
			default: in_clk = i_clock_input_a;
		endcase
		pwr_down = regs_q[reg_idx(ocm_pkg::OFS_PWR)][ocm_pkg::POWER_DOWN_BIT] ||
			(pwr_func == ocm_pkg::PWR_FUNC_PD && !i_power_control_pin); // RQ7
		bypass = !pwr_down && pwr_func == ocm_pkg::PWR_FUNC_BYPASS && !i_power_control_pin;
	end

	assign o_input_clock = in_clk;
	assign o_pll_power_down = pwr_down || bypass;
	assign o_input_stage_power_down = pwr_down; // RQ7

	// ************************************************************
	// Post-dividers and output matrix
	// ************************************************************
	function automatic logic pick_source(input logic [2:0] code, input logic clk_in,
		input ocm_pkg::ocm_pll_clks_t plls);
		case (code)
			ocm_pkg::DSRC_BYPASS: pick_source = clk_in;
			ocm_pkg::DSRC_PLL1: pick_source = plls.pll1;
			ocm_pkg::DSRC_PLL2: pick_source = plls.pll2;
			ocm_pkg::DSRC_PLL2_SSC: pick_source = plls.pll2_ssc;
			ocm_pkg::DSRC_PLL3: pick_source = plls.pll3;
			default: pick_source = 1'b0;
		endcase
	endfunction

	logic [ocm_pkg::NUM_OUT-1:0] div_clk;

	genvar g;
	generate
		for (g = 0; g < ocm_pkg::NUM_OUT; g++) begin : g_lane
			logic [2:0] dsrc;
			logic [7:0] dsrc_byte;
			logic div_src, lane_clk;
			ocm_pkg::ocm_out_cfg_t cfg;

			assign dsrc_byte = regs_q[reg_idx(ocm_pkg::OFS_DSRC01) + 5'(g / 2)];
			assign dsrc = dsrc_byte[(g % 2) * 4 +: ocm_pkg::SEL_W];
			assign div_src = pick_source(dsrc, in_clk, i_pll_clks); // RQ14
			assign cfg = ocm_pkg::ocm_out_cfg_t'(regs_q[reg_idx(ocm_pkg::OFS_OUT0) + 5'(g)]);

			ocm_post_divider #(
				.RATIO_W(ocm_pkg::DIV_RATIO_W)
			) u_div (
				.i_clock(i_clock),
				.i_rst(i_rst),
				.i_src(div_src),
				.i_ratio(regs_q[reg_idx(ocm_pkg::OFS_DIV0) + 5'(g)][6:0]),
				.o_clk(div_clk[g])
			);

			// Bypass test mode skips the dividers and PLLs entirely
			assign lane_clk = bypass ? in_clk :
				((cfg.source <= 3'h5) ? div_clk[cfg.source] : 1'b0); // RQ11

			ocm_output_lane u_lane (
				.i_clock(i_clock),
				.i_rst(i_rst),
				.i_clk_src(lane_clk),
				.i_enable(cfg.enable),
				.i_invert(cfg.invert),
				.i_ctl_func(ctl_func),
				.i_ctl_pin(i_output_control_pin),
				.i_power_down(pwr_down), // RQ8
				.o_out(o_clock_output_n[g]),
				.o_oe(o_clock_output_oe[g])
			);
		end
	endgenerate

endmodule // ocm_top

// *** ocm_pkg.sv ***
// Shared constants, field layouts and types of the output clock matrix
package ocm_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] OFS_CTL_PIN = 8'h0A;
	localparam logic [7:0] OFS_IN_SRC = 8'h0B;
	localparam logic [7:0] OFS_PWR = 8'h0C;
	localparam logic [7:0] OFS_DIV0 = 8'h0D;
	localparam logic [7:0] OFS_OUT0 = 8'h13;
	localparam logic [7:0] OFS_SSC_GAP = 8'h19;
	localparam logic [7:0] OFS_CNT_GAP = 8'h1A;
	localparam logic [7:0] OFS_DSRC01 = 8'h1B;
	localparam logic [7:0] OFS_LAST = 8'h1D;
	localparam int NUM_REGS = 20;
	localparam int NUM_OUT = 6;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CTL_FUNC_LSB = 2;
	localparam int INPUT_SELECT_BIT = 4;
	localparam int INPUT_SOURCE_LSB = 6;
	localparam int POWER_DOWN_BIT = 6;
	localparam int PWR_FUNC_LSB = 0;
	localparam int DIV_RATIO_W = 7;
	localparam int SEL_W = 3;

	// ************************************************************
	// Codes
	// ************************************************************
	localparam logic [1:0] CTL_FORCE_LOW = 2'h0;
	localparam logic [1:0] CTL_HIGH_Z = 2'h1;
	localparam logic [1:0] SRC_CRYSTAL = 2'h0;
	localparam logic [1:0] SRC_SINGLE = 2'h1;
	localparam logic [1:0] SRC_DIFF = 2'h2;
	localparam logic [1:0] PWR_FUNC_PD = 2'h0;
	localparam logic [1:0] PWR_FUNC_BYPASS = 2'h1;
	localparam logic [1:0] PWR_FUNC_INSEL = 2'h2;
	localparam logic [2:0] DSRC_BYPASS = 3'h0;
	localparam logic [2:0] DSRC_PLL1 = 3'h1;
	localparam logic [2:0] DSRC_PLL2 = 3'h2;
	localparam logic [2:0] DSRC_PLL2_SSC = 3'h3;
	localparam logic [2:0] DSRC_PLL3 = 3'h4;

	// ************************************************************
	// Reset values, indexed by offset minus OFS_CTL_PIN
	// ************************************************************
	localparam logic [7:0] RESET_BYTES [NUM_REGS] = '{
		8'h00, 8'h00, 8'h00,
		8'h0A, 8'h14, 8'h08, 8'h09, 8'h20, 8'h04,
		8'h3A, 8'h3A, 8'h3A, 8'h3A, 8'h3A, 8'h3A,
		8'h00, 8'h00,
		8'h42, 8'h11, 8'h11
	};

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic spare;
		logic invert;
		logic [1:0] slew;
		logic enable;
		logic [2:0] source;
	} ocm_out_cfg_t;

	typedef struct packed {
		logic pll3;
		logic pll2_ssc;
		logic pll2;
		logic pll1;
	} ocm_pll_clks_t;

endpackage

// *** ocm_post_divider.sv ***
// Seven-bit post-divider of one selected source clock
`timescale 1ns/100ps
module ocm_post_divider #(
	parameter int RATIO_W = 7
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Source and ratio
	input wire logic i_src,
	input wire logic [RATIO_W-1:0] i_ratio,
	// Divided clock
	output logic o_clk
);

	logic src_q, src_d;
	logic [RATIO_W-1:0] cnt_q, cnt_d;
	logic out_q, out_d;
	logic [RATIO_W-1:0] half;

	always_comb begin
		src_d = i_src;
		cnt_d = cnt_q;
		out_d = out_q;
		// One bit wider so the top ratio cannot wrap to a zero high time
		half = RATIO_W'(({1'b0, i_ratio} + (RATIO_W + 1)'(1)) >> 1);
		if (i_ratio == '0) begin
			// Undefined ratio: hold low rather than run wild
			out_d = 1'b0;
			cnt_d = '0;
		end else if (i_ratio == RATIO_W'(1)) begin
			out_d = i_src; // RQ9
			cnt_d = '0;
		end else if (i_src && !src_q) begin
			cnt_d = (cnt_q >= i_ratio - 1'b1) ? '0 : cnt_q + 1'b1; // RQ9
			out_d = (cnt_d < half);
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			src_q <= 1'b0;
			cnt_q <= '0;
			out_q <= 1'b0;
		end else begin
			src_q <= src_d;
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign o_clk = out_q;

endmodule // ocm_post_divider

// *** ocm_output_lane.sv ***
// One clock output: enable, inversion, control-pin and power-down gating
`timescale 1ns/100ps
module ocm_output_lane (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Selected clock and settings
	input wire logic i_clk_src,
	input wire logic i_enable,
	input wire logic i_invert,
	input wire logic [1:0] i_ctl_func,
	input wire logic i_ctl_pin,
	input wire logic i_power_down,
	// Pin
	output logic o_out,
	output logic o_oe
);

	logic out_q, out_d;
	logic oe_q, oe_d;

	always_comb begin
		out_d = 1'b0;
		oe_d = 1'b1;
		if (i_power_down) begin
			oe_d = 1'b0; // RQ7 RQ8
		end else if (!i_ctl_pin && i_ctl_func == ocm_pkg::CTL_FORCE_LOW) begin
			out_d = i_invert; // RQ1
		end else if (!i_ctl_pin && i_ctl_func == ocm_pkg::CTL_HIGH_Z) begin
			oe_d = 1'b0; // RQ2
		end else if (!i_enable) begin
			out_d = 1'b0; // RQ12
		end else begin
			out_d = i_clk_src ^ i_invert; // RQ12 RQ13
		end
	end

	// Reset state is tri-stated until the first clock is seen
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			out_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	assign o_out = out_q;
	assign o_oe = oe_q;

endmodule // ocm_output_lane

// *** ocm_top_monitor.sv ***
// Port checker of the output clock matrix
`timescale 1ns/100ps
module ocm_top_monitor (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Watched ports
	input wire logic i_scl,
	input wire logic i_output_control_pin,
	input wire logic o_sda_out,
	input wire logic o_sda_oe,
	input wire logic o_pll_power_down,
	input wire logic o_input_stage_power_down,
	input wire logic [ocm_pkg::NUM_OUT-1:0] o_clock_output_n,
	input wire logic [ocm_pkg::NUM_OUT-1:0] o_clock_output_oe
);
	wire logic pd = o_input_stage_power_down;
	wire logic pin = i_output_control_pin;
	wire logic [ocm_pkg::NUM_OUT-1:0] oe = o_clock_output_oe;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	property p_pd_tristate;
		pd |=> oe == '0;
	endproperty
	a_pd_tristate: assert property (p_pd_tristate) else $error("driven in power-down");
	property p_pd_plls;
		pd |-> o_pll_power_down;
	endproperty
	a_pd_plls: assert property (p_pd_plls) else $error("PLLs run in power-down");
	property p_pd_wins;
		(pd && !pin) [*2] |-> oe == '0;
	endproperty
	a_pd_wins: assert property (p_pd_wins) else $error("pin beat power-down");
	property p_oe_group;
		oe == '0 || oe == '1;
	endproperty
	a_oe_group: assert property (p_oe_group) else $error("mixed output drive");
	property p_oe_active;
		(pin && !pd) ##1 (pin && !pd) |-> oe == '1;
	endproperty
	a_oe_active: assert property (p_oe_active) else $error("outputs not driven");
	// Holds unless an invert bit or the control function is rewritten while the pin is low
	property p_ctl_freeze;
		(!pin && !pd) ##1 (!pin && !pd) |=>
			$stable(oe) && (oe == '0 || $stable(o_clock_output_n));
	endproperty
	a_ctl_freeze: assert property (p_ctl_freeze) else $error("outputs move while held");
	property p_sda_scl_low;
		$changed(o_sda_oe) |-> !i_scl;
	endproperty
	a_sda_scl_low: assert property (p_sda_scl_low) else $error("SDA moved with SCL high");
	property p_sda_low;
		o_sda_oe |-> !o_sda_out;
	endproperty
	a_sda_low: assert property (p_sda_low) else $error("SDA driven high");
	c_pd: cover property (pd ##1 oe == '0);
	c_forced: cover property (!pin && oe == '1);
	c_ack: cover property ($rose(o_sda_oe));
endmodule // ocm_top_monitor
bind ocm_top ocm_top_monitor u_mon (.i_clock(i_clock), .i_rst(i_rst), .i_scl(i_scl),
	.i_output_control_pin(i_output_control_pin), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
	.o_pll_power_down(o_pll_power_down), .o_input_stage_power_down(o_input_stage_power_down),
	.o_clock_output_n(o_clock_output_n), .o_clock_output_oe(o_clock_output_oe));

// *** ocm_host_model.sv ***
// Management bus host model for register writes and reads
`timescale 1ns/100ps
module ocm_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h50
) (
	// Clock and wired bus line
	input wire logic i_clock,
	input wire logic i_sda,
	// Bus drive
	output logic o_scl,
	output logic o_sda_low
);
	// Four clocks a phase, above the three-clock minimum
	localparam int PH = 4;
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic gap(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	// Waits first so a held acknowledge is gone before SCL rises
	task automatic start_c();
		o_sda_low = 1'b0;
		gap(PH);
		o_scl = 1'b1;
		gap(PH);
		o_sda_low = 1'b1;
		gap(PH);
		o_scl = 1'b0;
	endtask
	task automatic stop_c();
		gap(1);
		o_sda_low = 1'b1;
		gap(PH);
		o_scl = 1'b1;
		gap(PH);
		o_sda_low = 1'b0;
		gap(PH);
	endtask
	task automatic slot(input logic b, output logic got);
		gap(1);
		o_sda_low = ~b;
		gap(PH);
		o_scl = 1'b1;
		gap(PH / 2);
		got = i_sda;
		gap(PH / 2);
		o_scl = 1'b0;
	endtask
	// Ninth slot is always released: acknowledge check, or end of a read
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			slot(tx[i], g);
			rx[i] = g;
		end
		slot(1'b1, g);
		ack = ~g;
	endtask
	// Only defined codes and nonzero ratios are ever handed in
	task automatic access(input logic rd, input logic [7:0] ofs, input logic [7:0] wdat,
		output logic [7:0] rdat, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2;
		start_c();
		xfer({DEV_ADDR, 1'b0}, r, a0);
		xfer(ofs, r, a1);
		if (rd) begin
			start_c();
			xfer({DEV_ADDR, 1'b1}, r, a2);
			xfer(8'hFF, rdat, r[0]);
		end else begin
			xfer(wdat, r, a2);
		end
		stop_c();
		ok = a0 & a1 & a2;
	endtask
endmodule // ocm_host_model

// *** test_ocm_top.sv ***
// Self-checking bench of the output clock matrix
`timescale 1ns/100ps
module test_ocm_top;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic out_pin = 1'b1;
	logic pwr_pin = 1'b1;
	logic hold = 1'b0;
	logic ha = 1'b0;
	logic hb = 1'b0;
	logic scl, sda_low, sda_oe, sda_out, in_clk, pll_pd, in_pd;
	logic [5:0] y, y_oe;
	int t = 0;
	int cycles = 0;
	int n_errors = 0;
	int n_compared = 0;
	wire sda_line = ~(sda_low | (sda_oe & ~sda_out));
	wire in_a = hold ? ha : (t % 10 < 5);
	wire in_b = hold ? hb : (t % 14 < 7);
	// Each source has its own period, so a wrong pick shows in the output period
	wire ocm_pkg::ocm_pll_clks_t plls = {t[2], t % 6 < 3, t[1], t[0]};
	localparam logic [7:0] RATIO [6] = '{8'h0A, 8'h14, 8'h08, 8'h09, 8'h20, 8'h04};
	localparam int SPER [6] = '{4, 8, 2, 2, 2, 2};
	localparam logic [7:0] DRAT [5] = '{8'h03, 8'h7F, 8'h03, 8'h02, 8'h01};
	localparam int DPER [5] = '{30, 254, 12, 12, 8};
	localparam logic [7:0] S_CTL [7] = '{8'h00, 8'h10, 8'h10, 8'h10, 8'h00, 8'h10, 8'h00};
	localparam logic [7:0] S_SRC [7] = '{8'h00, 8'h00, 8'h80, 8'h40, 8'h40, 8'h40, 8'h40};
	localparam logic [6:0] S_PIN = 7'h5F;
	localparam logic [6:0] S_B = 7'h48;
	ocm_top DUT (.i_clock(i_clock), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_line),
		.o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_output_control_pin(out_pin),
		.i_power_control_pin(pwr_pin), .i_clock_input_a(in_a), .i_clock_input_b(in_b),
		.i_pll_clks(plls), .o_input_clock(in_clk), .o_pll_power_down(pll_pd),
		.o_input_stage_power_down(in_pd), .o_clock_output_n(y), .o_clock_output_oe(y_oe));
	ocm_host_model host (.i_clock(i_clock), .i_sda(sda_line), .o_scl(scl), .o_sda_low(sda_low));
	always #25 i_clock = ~i_clock;
	always @(negedge i_clock) begin
		t <= t + 1;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_errors++;
			results();
		end
	end
	// ********
	// Tasks
	// ********
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask
	task automatic clks(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic ok;
		host.access(1'b0, a, d, r, ok);
		chk(ok, 1, "write ack");
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		host.access(1'b1, a, 8'h00, d, ok);
		chk(ok, 1, "read ack");
		chk(d, e, "read data");
	endtask
	// Timed between second and third rising edge, clear of a ratio change
	task automatic meas(input int exp);
		int c = 0;
		int r = 0;
		int t0 = 0;
		logic p = y[0];
		while (r < 3 && c < 3000) begin
			clks(1);
			c++;
			if (y[0] === 1'b1 && p === 1'b0) begin
				r++;
				if (r == 3)
					chk(c - t0, exp, "period");
				t0 = c;
			end
			p = y[0];
		end
		if (r < 3)
			chk(r, 3, "edges");
	endtask
	task automatic results();
		$display("Counts: %0d compared, %0d mismatched", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ********
	// Tests
	// ********
	initial begin
		repeat (5) @(negedge i_clock);
		i_rst = 1'b0;
		clks(3);
		for (int i = 0; i < 3; i++)
			rdc(ocm_pkg::OFS_CTL_PIN + 8'(i), 8'h00);
		for (int i = 0; i < 6; i++) begin
			rdc(ocm_pkg::OFS_DIV0 + 8'(i), RATIO[i]);
			rdc(ocm_pkg::OFS_OUT0 + 8'(i), 8'h3A);
		end
		wr(8'h19, 8'h55);
		rdc(8'h19, 8'h00);
		meas(16);
		$display("test defaults done");
		for (int k = 0; k < 6; k++) begin
			wr(ocm_pkg::OFS_OUT0, 8'h38 | 8'(k));
			meas(int'(RATIO[k]) * SPER[k]);
		end
		wr(ocm_pkg::OFS_OUT0, 8'h38);
		for (int r = 0; r < 5; r++) begin
			wr(ocm_pkg::OFS_DSRC01, 8'h40 | 8'(r));
			wr(ocm_pkg::OFS_DIV0, DRAT[r]);
			meas(DPER[r]);
		end
		$display("test routing done");
		wr(ocm_pkg::OFS_OUT0, 8'h3A);
		wr(ocm_pkg::OFS_OUT0 + 8'h01, 8'h7A);
		wr(ocm_pkg::OFS_OUT0 + 8'h02, 8'h72);
		meas(16);
		for (int i = 0; i < 40; i++) begin
			clks(1);
			chk(y[1], !y[0], "invert");
			chk(y[2], 1'b0, "disable");
		end
		out_pin = 1'b0;
		clks(3);
		chk({y_oe, y}, 12'hFC6, "forced");
		out_pin = 1'b1;
		wr(ocm_pkg::OFS_CTL_PIN, 8'h04);
		out_pin = 1'b0;
		clks(3);
		chk(y_oe, 6'h00, "tristate");
		out_pin = 1'b1;
		wr(ocm_pkg::OFS_CTL_PIN, 8'h00);
		out_pin = 1'b0;
		wr(ocm_pkg::OFS_PWR, 8'h40);
		clks(2);
		chk({y_oe, pll_pd, in_pd}, 8'h03, "power down");
		rdc(ocm_pkg::OFS_DIV0, 8'h01);
		out_pin = 1'b1;
		wr(ocm_pkg::OFS_PWR, 8'h00);
		clks(2);
		chk(y_oe, 6'h3F, "resume");
		wr(ocm_pkg::OFS_PWR, 8'h01);
		pwr_pin = 1'b0;
		clks(2);
		chk({y_oe, pll_pd, in_pd}, 8'hFE, "bypass");
		meas(10);
		pwr_pin = 1'b1;
		$display("test output control done");
		hold = 1'b1;
		for (int r = 0; r < 7; r++) begin
			wr(ocm_pkg::OFS_CTL_PIN, S_CTL[r]);
			wr(ocm_pkg::OFS_IN_SRC, S_SRC[r]);
			wr(ocm_pkg::OFS_PWR, (r >= 5) ? 8'h02 : 8'h00);
			pwr_pin = S_PIN[r];
			for (int v = 0; v < 2; v++) begin
				ha = v[0];
				hb = ~v[0];
				clks(3);
				chk(in_clk, S_B[r] ? hb : ha, "input select");
			end
		end
		$display("test input select done");
		results();
	end
endmodule // test_ocm_top
